// *** common/ohbp_cfg.svh ***
// Constants of the display host bus port
`ifndef OHBP_CFG_SVH
`define OHBP_CFG_SVH
`define OHBP_MODE_I2C 2'b01
`define OHBP_MODE_SPI 2'b00
`define OHBP_MODE_P68 2'b11
`define OHBP_MODE_P80 2'b10
`define OHBP_I2C_ADDR_BASE 7'h3C
`define OHBP_FIFO_DEPTH 16
`define OHBP_COL_W 7
`define OHBP_CTRL_CO_BIT 7
`define OHBP_CTRL_DC_BIT 6
`endif

// *** common/ohbp_pkg.sv ***
// Types of the display host bus port
package ohbp_pkg;
    typedef struct packed {
        logic       is_data;
        logic [7:0] value;
    } ohbp_word_t;
    typedef enum logic [3:0] {
        OHBP_I_IDLE = 4'b0001,
        OHBP_I_ADDR = 4'b0010,
        OHBP_I_BYTE = 4'b0100,
        OHBP_I_SKIP = 4'b1000
    } ohbp_i2c_st_t;
endpackage

// *** logic/ohbp_fifo.sv ***
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ohbp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;
    assign o_in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign o_out_valid = wr_q != rd_q;
    assign o_out_data = mem[rd_q[AW-1:0]];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= i_in_data;
        end
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // ohbp_fifo
`default_nettype wire

// *** logic/ohbp_port.sv ***
// Host bus port: parallel, 4-wire serial and I2C front end of the display controller
`timescale 1ns/1ps
`default_nettype none
`include "ohbp_cfg.svh"
// Functional notes
// - Traffic only while chip select low
// - Low chip reset initializes the port
// - Data/command pin routes byte to RAM/command
// - I2C mode: D/C pin is address lsb
// - Style 68: read/write high reads, low writes
// - Style 80: write strobe falling starts write
// - Style 68: enable high starts transfer
// - Style 80: read strobe falling starts read
// - Serial: D0 clock, D1 data, D2 unused
// - I2C: D1/D2 data line, D0 clock
// - Straps choose link; I2C is a=1,b=0
// - I2C address 0111100 or 0111101
// - Control byte: continuation, data/command, six zeros
// - I2C flag 0 command, 1 RAM data
// - Column pointer increments after data write
module ohbp_port
    import ohbp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_chip_reset_n,
    input wire logic i_chip_sel_n,
    input wire logic i_bus_select_strap_a,
    input wire logic i_bus_select_strap_b,
    input wire logic i_dc_sel,
    input wire logic i_rw_wr_n,
    input wire logic i_en_rd_n,
    input wire logic [7:0] i_data_pin,
    output logic [7:0] o_data_pin,
    output logic [7:0] o_data_pin_oe,
    input wire logic [7:0] i_read_data,
    output logic o_word_valid,
    input wire logic i_word_ready,
    output logic o_word_is_data,
    output logic [7:0] o_word_value,
    output logic [6:0] o_col_addr,
    output logic o_read_strobe,
    output logic o_overflow
);
    logic [11:0] s1_q;
    logic [11:0] s2_q;
    logic cs_n, dc, rw, en, scl, sda;
    logic [1:0] mode_q;
    logic chip_rst_n;
    assign {chip_rst_n, cs_n, dc, rw, en} = s2_q[11:7];
    assign scl = s2_q[0];
    assign sda = s2_q[1];
    // Two-flop synchronisers on every pin
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= 12'hFFF;
            s2_q <= 12'hFFF;
        end else begin
            s1_q <= {i_chip_reset_n, i_chip_sel_n, i_dc_sel, i_rw_wr_n, i_en_rd_n, i_data_pin[6:0]};
            s2_q <= s1_q;
        end
    end
    logic [7:0] dbus;
    logic [7:0] d7_s1_q;
    logic [7:0] d7_s2_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            d7_s1_q <= 8'h00;
            d7_s2_q <= 8'h00;
        end else begin
            d7_s1_q <= i_data_pin;
            d7_s2_q <= d7_s1_q;
        end
    end
    assign dbus = d7_s2_q;
    // Straps are pins too, so they pass their own two-flop synchroniser
    logic [1:0] strap_s1_q;
    logic [1:0] strap_s2_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_s1_q <= 2'h0;
            strap_s2_q <= 2'h0;
        end else begin
            strap_s1_q <= {i_bus_select_strap_b, i_bus_select_strap_a};
            strap_s2_q <= strap_s1_q;
        end
    end
    // Strap sampled while the chip is held in reset
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q <= `OHBP_MODE_SPI;
        end else if (!chip_rst_n) begin
            mode_q <= strap_s2_q;
        end
    end
    logic rw_q, en_q, scl_q, sda_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {rw_q, en_q, scl_q, sda_q} <= 4'hF;
        end else begin
            {rw_q, en_q, scl_q, sda_q} <= {rw, en, scl, sda};
        end
    end
    logic sel, par_wr, par_rd, par_rd_act;
    assign sel = !cs_n && chip_rst_n;
    always_comb begin
        par_wr = 1'b0;
        par_rd = 1'b0;
        par_rd_act = 1'b0;
        if (sel && mode_q == `OHBP_MODE_P68) begin
            par_wr = en && !en_q && !rw;
            par_rd = en && !en_q && rw;
            par_rd_act = en && rw;
        end else if (sel && mode_q == `OHBP_MODE_P80) begin
            par_wr = !rw && rw_q;
            par_rd = !en && en_q;
            par_rd_act = !en;
        end
    end
    // Serial shift: D0 clock, D1 data, sampled on rising clock
    logic [2:0] sp_cnt_q;
    logic [7:0] sp_sh_q;
    logic sp_done;
    logic scl_rise, scl_fall;
    assign scl_rise = scl && !scl_q;
    assign scl_fall = !scl && scl_q;
    assign sp_done = sel && mode_q == `OHBP_MODE_SPI && scl_rise && sp_cnt_q == 3'd7;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp_cnt_q <= 3'd0;
            sp_sh_q <= 8'h00;
        end else if (!sel || mode_q != `OHBP_MODE_SPI) begin
            sp_cnt_q <= 3'd0;
        end else if (scl_rise) begin
            sp_sh_q <= {sp_sh_q[6:0], sda};
            sp_cnt_q <= sp_cnt_q + 3'd1;
        end
    end
    // I2C slave (write direction only)
    ohbp_i2c_st_t ist_q;
    logic [3:0] ibit_q;
    logic [7:0] ish_q;
    logic ictrl_q, ico_q, idc_q, iack_q, i2c_on;
    logic i2c_start, i2c_stop, i_byte, i_word;
    assign i2c_on = sel && mode_q == `OHBP_MODE_I2C;
    assign i2c_start = scl && scl_q && !sda && sda_q;
    assign i2c_stop = scl && scl_q && sda && !sda_q;
    assign i_byte = scl_rise && ibit_q == 4'd7;
    assign i_word = ist_q == OHBP_I_BYTE && i_byte && !ictrl_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ist_q <= OHBP_I_IDLE;
            ibit_q <= 4'd0;
            ish_q <= 8'h00;
            ictrl_q <= 1'b1;
            ico_q <= 1'b1;
            idc_q <= 1'b0;
            iack_q <= 1'b0;
        end else if (!i2c_on || i2c_stop) begin
            ist_q <= OHBP_I_IDLE;
            iack_q <= 1'b0;
        end else if (i2c_start) begin
            ist_q <= OHBP_I_ADDR;
            ibit_q <= 4'd0;
            ictrl_q <= 1'b1;
            ico_q <= 1'b1;
            iack_q <= 1'b0;
        end else begin
            if (scl_rise && ibit_q < 4'd8) begin
                ish_q <= {ish_q[6:0], sda};
            end
            if (scl_rise) begin
                ibit_q <= (ibit_q == 4'd8) ? 4'd0 : ibit_q + 4'd1;
            end
            if (scl_fall && ibit_q == 4'd8) begin
                iack_q <= 1'b1;
            end else if (scl_fall) begin
                iack_q <= 1'b0;
            end
            case (ist_q)
                OHBP_I_IDLE: begin
                    iack_q <= 1'b0;
                end
                OHBP_I_ADDR: begin
                    if (i_byte) begin
                        // Address sits in bits 7..1; only the write direction is answered
                        if (ish_q[6:0] == (`OHBP_I2C_ADDR_BASE | {6'h00, dc}) && !sda) begin
                            ist_q <= OHBP_I_BYTE;
                        end else begin
                            ist_q <= OHBP_I_SKIP;
                        end
                    end
                end
                OHBP_I_BYTE: begin
                    if (i_byte && ictrl_q) begin
                        ico_q <= ish_q[`OHBP_CTRL_CO_BIT-1];
                        idc_q <= ish_q[`OHBP_CTRL_DC_BIT-1];
                        ictrl_q <= ish_q[`OHBP_CTRL_CO_BIT-1];
                    end else if (i_byte && ico_q) begin
                        ictrl_q <= 1'b1;
                    end
                end
                OHBP_I_SKIP: begin
                    iack_q <= 1'b0;
                end
                default: ist_q <= OHBP_I_IDLE;
            endcase
        end
    end
    // Merge the sources into the FIFO
    logic f_valid, f_ready, f_ovf, f_have;
    ohbp_word_t f_in, f_out;
    always_comb begin
        f_valid = par_wr || sp_done || i_word;
        f_in.is_data = dc;
        f_in.value = dbus;
        if (sp_done) begin
            f_in.value = {sp_sh_q[6:0], sda};
        end else if (i_word) begin
            f_in.is_data = idc_q;
            f_in.value = {ish_q[6:0], sda};
        end
    end
    assign f_ovf = f_valid && !f_ready;
    ohbp_fifo #(.WIDTH(9), .DEPTH(`OHBP_FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(f_valid && chip_rst_n),
        .o_in_ready(f_ready),
        .i_in_data(f_in),
        .o_out_valid(f_have),
        .i_out_ready(i_word_ready && !o_word_valid),
        .o_out_data(f_out)
    );
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_word_valid <= 1'b0;
            o_word_is_data <= 1'b0;
            o_word_value <= 8'h00;
            o_col_addr <= '0;
            o_overflow <= 1'b0;
        end else if (!chip_rst_n) begin
            o_word_valid <= 1'b0;
            o_col_addr <= '0;
            o_overflow <= 1'b0;
        end else begin
            if (f_ovf) begin
                o_overflow <= 1'b1;
            end
            if (o_word_valid) begin
                o_word_valid <= 1'b0;
                if (o_word_is_data) begin
                    o_col_addr <= o_col_addr + 7'd1;
                end
            end else if (i_word_ready && f_have) begin
                o_word_valid <= 1'b1;
                o_word_is_data <= f_out.is_data;
                o_word_value <= f_out.value;
            end
        end
    end
    // Pin drivers: parallel read data and I2C acknowledge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data_pin <= 8'h00;
            o_data_pin_oe <= 8'h00;
            o_read_strobe <= 1'b0;
        end else begin
            o_read_strobe <= par_rd && chip_rst_n;
            o_data_pin <= i_read_data;
            o_data_pin_oe <= 8'h00;
            if (sel && par_rd_act) begin
                o_data_pin_oe <= 8'hFF;
            end else if (i2c_on && iack_q) begin
                o_data_pin <= 8'h00;
                o_data_pin_oe <= 8'h04;
            end
        end
    end
endmodule // ohbp_port
`default_nettype wire

// *** test/ohbp_host_model.sv ***
// Host microcontroller model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module ohbp_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_bus,
    output logic o_cs_n,
    output logic o_dc,
    output logic o_rw,
    output logic o_en,
    output logic [7:0] o_d
);
    logic ack;
    logic [7:0] rdq;
    initial begin
        o_cs_n = 1'b1;
        o_dc = 1'b0;
        o_rw = 1'b1;
        o_en = 1'b1;
        o_d = 8'h00;
    end
    task automatic gap();
        repeat (5) @(negedge i_core_clk);
    endtask
    task automatic idle(input bit s80, input logic [7:0] dv);
        o_rw = s80;
        o_en = s80;
        o_d = dv;
    endtask
    task automatic par(input bit s80, input bit rd, input bit sel, input logic dv,
                       input logic [7:0] v);
        @(negedge i_core_clk);
        o_cs_n = ~sel;
        o_dc = dv;
        o_rw = s80 | rd;
        o_d = rd ? ~o_d : v;
        gap();
        if (!s80) o_en = 1'b1;
        else if (rd) o_en = 1'b0;
        else o_rw = 1'b0;
        gap();
        rdq = i_bus;
        o_en = s80;
        o_rw = s80 | rd;
        gap();
        o_cs_n = 1'b1;
        gap();
    endtask
    task automatic bit_out(input logic b);
        o_d[1] = b;
        gap();
        o_d[0] = 1'b1;
        gap();
        ack = ~i_bus[1];
        o_d[0] = 1'b0;
        gap();
    endtask
    task automatic spi(input logic dv, input logic [7:0] v);
        o_cs_n = 1'b0;
        o_dc = dv;
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        o_cs_n = 1'b1;
        gap();
    endtask
    task automatic i2c(input bit st, input logic dv, input logic [7:0] v);
        o_cs_n = 1'b0;
        o_dc = dv;
        if (st) begin
            o_d[1] = 1'b0;
            gap();
            o_d[0] = 1'b0;
            gap();
        end
        for (int i = 7; i >= 0; i--) bit_out(v[i]);
        bit_out(1'b1);
    endtask
    task automatic stop();
        o_d[1] = 1'b0;
        gap();
        o_d[0] = 1'b1;
        gap();
        o_d[1] = 1'b1;
        gap();
    endtask
endmodule // ohbp_host_model
`default_nettype wire

// *** test/ohbp_port_sva.sv ***
// Assertions on the host bus port outputs
`timescale 1ns/1ps
`default_nettype none
module ohbp_port_sva (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_chip_reset_n,
    input wire logic i_bus_select_strap_b,
    input wire logic [7:0] o_data_pin_oe,
    input wire logic o_word_valid,
    input wire logic o_word_is_data,
    input wire logic [7:0] o_word_value,
    input wire logic [6:0] o_col_addr,
    input wire logic o_read_strobe,
    input wire logic o_overflow
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_data_word;
        o_word_valid && o_word_is_data;
    endsequence
    sequence s_run;
        i_chip_reset_n [*4];
    endsequence
    property p_col_step;
        s_data_word |=> o_col_addr == $past(o_col_addr) + 7'h01;
    endproperty
    a_col_step: assert property (p_col_step) else $error("col not stepped");
    property p_col_cause;
        $changed(o_col_addr) && o_col_addr != 7'h00 |-> $past(o_word_valid && o_word_is_data);
    endproperty
    a_col_cause: assert property (p_col_cause) else $error("col moved alone");
    property p_cmd_hold;
        o_word_valid && !o_word_is_data |=> $stable(o_col_addr);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("col moved on cmd");
    property p_word_hold;
        s_run ##0 !o_word_valid |-> $stable({o_word_is_data, o_word_value});
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word changed");
    property p_oe_par;
        o_data_pin_oe == 8'hFF |-> i_bus_select_strap_b;
    endproperty
    a_oe_par: assert property (p_oe_par) else $error("bus driven off parallel");
    property p_oe_i2c;
        o_data_pin_oe == 8'h04 |-> !i_bus_select_strap_b;
    endproperty
    a_oe_i2c: assert property (p_oe_i2c) else $error("ack off serial");
    property p_rd_pulse;
        o_read_strobe |=> !o_read_strobe;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe long");
    property p_ovf_keep;
        s_run ##0 o_overflow |=> o_overflow;
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("overflow lost");
endmodule // ohbp_port_sva
bind ohbp_port ohbp_port_sva chk_u (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_chip_reset_n(i_chip_reset_n),
    .i_bus_select_strap_b(i_bus_select_strap_b), .o_data_pin_oe(o_data_pin_oe),
    .o_word_valid(o_word_valid), .o_word_is_data(o_word_is_data),
    .o_word_value(o_word_value), .o_col_addr(o_col_addr),
    .o_read_strobe(o_read_strobe), .o_overflow(o_overflow)
);
`default_nettype wire

// *** test/ohbp_port_test.sv ***
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module ohbp_port_test;
    logic clk, rst_n, chip_rst_n, sa, sb, ready, i2c_on, cs_n, dc, rw, en, vld, isd, rstb, ovf;
    logic [7:0] hd, pin, oe, bus, val;
    logic [6:0] col;
    logic [8:0] q[$];
    int err_total;
    int n_checks;
    int n_rd;
    always_comb begin
        bus = (pin & oe) | (hd & ~oe);
        if (i2c_on) bus[1] = hd[1] & ~(oe[2] & ~pin[2]);
    end
    ohbp_host_model host_u (.i_core_clk(clk), .i_bus(bus), .o_cs_n(cs_n), .o_dc(dc),
        .o_rw(rw), .o_en(en), .o_d(hd));
    ohbp_port dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_chip_reset_n(chip_rst_n),
        .i_chip_sel_n(cs_n), .i_bus_select_strap_a(sa), .i_bus_select_strap_b(sb),
        .i_dc_sel(dc), .i_rw_wr_n(rw), .i_en_rd_n(en), .i_data_pin(bus), .o_data_pin(pin),
        .o_data_pin_oe(oe), .i_read_data(8'h5A), .o_word_valid(vld), .i_word_ready(ready),
        .o_word_is_data(isd), .o_word_value(val), .o_col_addr(col),
        .o_read_strobe(rstb), .o_overflow(ovf));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (vld) q.push_back({isd, val});
    always @(posedge clk) if (rstb) n_rd++;
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic word(input logic [8:0] exp);
        for (int n = 0; n < 300 && q.size() == 0; n++) @(negedge clk);
        if (q.size() == 0) begin
            err_total++;
            finish_test();
        end else begin
            chk(q.pop_front(), exp);
        end
    endtask
    task automatic mode(input logic b, input logic a, input logic [7:0] dv);
        @(negedge clk);
        sb = b;
        sa = a;
        i2c_on = a & ~b;
        host_u.idle(b & ~a, dv);
        chip_rst_n = 1'b0;
        repeat (4) @(negedge clk);
        chip_rst_n = 1'b1;
        repeat (4) @(negedge clk);
        chk({1'b0, ovf, col}, 9'h000);
    endtask
    initial begin
        err_total = 0;
        n_checks = 0;
        {rst_n, chip_rst_n, sa, sb, i2c_on, ready} = 6'h05;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        mode(1'b1, 1'b0, 8'h00);
        host_u.par(1, 0, 1, 0, 8'hAE);
        host_u.par(1, 0, 1, 1, 8'h55);
        host_u.par(1, 0, 1, 1, 8'hAA);
        word(9'h0AE);
        word(9'h155);
        word(9'h1AA);
        chk(9'(col), 9'h002);
        host_u.par(1, 1, 1, 0, 8'h00);
        chk(9'(host_u.rdq), 9'h05A);
        chk(9'(n_rd), 9'h001);
        chk(9'(oe), 9'h000);
        host_u.par(1, 0, 0, 1, 8'h77);
        repeat (20) @(negedge clk);
        chk(9'(q.size()), 9'h000);
        // Consumer stalled until the buffer refuses a word
        mode(1'b1, 1'b1, 8'h00);
        ready = 1'b0;
        for (int i = 0; i < 17; i++) host_u.par(0, 0, 1, 1, 8'(i));
        chk(9'(ovf), 9'h001);
        ready = 1'b1;
        for (int i = 0; i < 16; i++) word({1'b1, 8'(i)});
        host_u.par(0, 1, 1, 0, 8'h00);
        chk(9'(host_u.rdq), 9'h05A);
        chk(9'(n_rd), 9'h002);
        host_u.par(0, 0, 1, 0, 8'h81);
        word(9'h081);
        mode(1'b0, 1'b0, 8'h00);
        host_u.spi(1, 8'hC5);
        host_u.spi(0, 8'h21);
        word(9'h1C5);
        word(9'h021);
        mode(1'b0, 1'b1, 8'h03);
        host_u.i2c(1, 1, 8'h7A);
        chk(9'(host_u.ack), 9'h001);
        host_u.i2c(0, 1, 8'h40);
        host_u.i2c(0, 1, 8'h99);
        host_u.i2c(0, 1, 8'h66);
        host_u.stop();
        word(9'h199);
        word(9'h166);
        host_u.i2c(1, 1, 8'h78);
        chk(9'(host_u.ack), 9'h000);
        host_u.i2c(0, 1, 8'h12);
        host_u.stop();
        host_u.i2c(1, 0, 8'h78);
        chk(9'(host_u.ack), 9'h001);
        host_u.i2c(0, 0, 8'h00);
        host_u.i2c(0, 0, 8'hAF);
        host_u.stop();
        word(9'h0AF);
        finish_test();
    end
endmodule // ohbp_port_test
`default_nettype wire
